/* rtl/faceplate_alarm_indicators.sv */
// faceplate lamps, supply colour bands and alarm-silence control
// assumes pin inputs are asynchronous and the role and supply lamps are driven by colour codes
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps

// Function
// - red failure lamp held steadily lit while card reset is asserted
// - failure lamp flashes while booting or while a write is underway
// - role lamp green when active, amber when standby
// - role lamp blinks for the whole time a database write lasts
// - severe lamp red while any critical local alarm exists
// - second-tier lamp red while any major local alarm exists
// - low-tier lamp amber while any minor local alarm exists
// - far-terminal lamp red on remote alarm, otherwise unlit
// - timing-lock lamp green only while timing is externally locked
// - silence button lights silence lamp green and opens audible relay
// - a new alarm during silencing cancels it; relay follows alarms
// - once silenced alarm clears, silence lamp and relay return idle
// - supply A lamp green between low and high thresholds
// - supply A lamp amber in the high or low margin bands
// - supply A lamp red beyond either extreme threshold
// - supply B lamp uses the same thresholds and bands as A
// - alarm raised whenever either supply leaves its range
module faceplate_alarm_indicators #(
  parameter int unsigned BLINK_HALF_CYC = faceplate_pkg::BLINK_HALF_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       card_reset_i,
  input  wire logic                       booting_i,
  input  wire logic                       writing_i,
  input  wire logic                       db_write_i,
  input  wire logic                       role_active_i,
  input  wire faceplate_pkg::alarm_in_t   alarms_i,
  input  wire logic                       timing_locked_i,
  input  wire logic                       silence_button_i,
  input  wire faceplate_pkg::supply_cmp_t supply_a_i,
  input  wire faceplate_pkg::supply_cmp_t supply_b_i,
  input  wire logic [3:0]                 reg_addr_i,
  input  wire logic [31:0]                reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic [31:0]                     reg_rdata_o,
  output logic                            irq_o,
  output logic                            fail_lamp_o,
  output faceplate_pkg::colour_t          role_lamp_o,
  output logic                            severe_alarm_lamp_o,
  output logic                            second_tier_alarm_lamp_o,
  output logic                            low_tier_alarm_lamp_o,
  output logic                            far_terminal_alarm_lamp_o,
  output logic                            timing_lock_lamp_o,
  output logic                            alarm_silence_lamp_o,
  output logic                            audible_relay_o,
  output faceplate_pkg::colour_t          supply_a_lamp_o,
  output faceplate_pkg::colour_t          supply_b_lamp_o,
  output logic                            supply_alarm_o
);

  // pin bits: five card levels, four alarm levels, lock,
  // button and two four-bit supply comparison sets
  localparam int unsigned NPIN = 19;

  // raw pin bundle, passed through a two-stage synchroniser
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;

  assign pin_raw = {card_reset_i, booting_i, writing_i, db_write_i,
                    role_active_i, alarms_i, timing_locked_i,
                    silence_button_i, supply_a_i, supply_b_i};

  // two flip-flops per pin bit
  // the first stage may go metastable, so only the
  // second stage is read by any logic
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (clk_en_i) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // unpack the synchronised bundle
  logic                       s_reset;
  logic                       s_boot;
  logic                       s_write;
  logic                       s_dbw;
  logic                       s_active;
  faceplate_pkg::alarm_in_t   s_alarm;
  logic                       s_lock;
  logic                       s_button;
  faceplate_pkg::supply_cmp_t s_sup_a;
  faceplate_pkg::supply_cmp_t s_sup_b;

  assign {s_reset, s_boot, s_write, s_dbw, s_active, s_alarm, s_lock,
          s_button, s_sup_a, s_sup_b} = sync2_q;

  // software-visible state
  logic [7:0]                           ctrl_q;
  logic [faceplate_pkg::DIV_W-1:0]      div_q;
  logic [faceplate_pkg::EV_W-1:0]       irq_st_q;
  logic [faceplate_pkg::EV_W-1:0]       irq_en_q;

  // blink divider: one source for every flashing pattern
  // blink_q toggles every div_q enabled cycles; a zero
  // divider is refused at the register write
  logic [faceplate_pkg::DIV_W-1:0] blink_cnt_q;
  logic                            blink_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (clk_en_i) begin
      if (blink_cnt_q >= div_q - 1'b1) begin
        blink_cnt_q <= '0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  // colour band from four ordered threshold flags
  // an extreme flag outranks a margin flag, so a stuck
  // comparator pair never reads as a healthy supply
  function automatic faceplate_pkg::colour_t band(
    input faceplate_pkg::supply_cmp_t c
  );
    if (c.above_ext_high || c.below_ext_low) begin
      band = faceplate_pkg::COL_RED;
    end else if (c.above_high || c.below_low) begin
      band = faceplate_pkg::COL_AMBER;
    end else begin
      band = faceplate_pkg::COL_GREEN;
    end
  endfunction : band

  faceplate_pkg::colour_t band_a;
  faceplate_pkg::colour_t band_b;
  logic                   sup_bad_a;
  logic                   sup_bad_b;
  logic                   blink_ok;
  logic                   any_alarm;

  // supply bands and the role-lamp blink gate; ctrl bit0
  // holds the role lamp steady through a database write
  assign band_a    = band(s_sup_a);
  assign band_b    = band(s_sup_b);
  assign sup_bad_a = (band_a != faceplate_pkg::COL_GREEN);
  assign sup_bad_b = (band_b != faceplate_pkg::COL_GREEN);
  assign blink_ok  = ctrl_q[faceplate_pkg::CTRL_BLINK_OFF] | blink_q;
  assign any_alarm = s_alarm.critical | s_alarm.major | s_alarm.minor
                   | s_alarm.remote | sup_bad_a | sup_bad_b;

  // card-level lamps
  // card reset outranks boot and write flashing; the role
  // lamp goes dark in each off phase while a database write lasts
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fail_lamp_o <= 1'b1;
      role_lamp_o <= faceplate_pkg::COL_OFF;
    end else if (clk_en_i) begin
      if (s_reset) begin
        fail_lamp_o <= 1'b1;
      end else if (s_boot || s_write) begin
        fail_lamp_o <= blink_q;
      end else begin
        fail_lamp_o <= 1'b0;
      end
      if (s_dbw && !blink_ok) begin
        role_lamp_o <= faceplate_pkg::COL_OFF;
      end else if (s_active) begin
        role_lamp_o <= faceplate_pkg::COL_GREEN;
      end else begin
        role_lamp_o <= faceplate_pkg::COL_AMBER;
      end
    end
  end

  // network-level and power-level lamps
  // each lamp is one edge behind the synchroniser, so
  // three edges behind its pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      severe_alarm_lamp_o       <= 1'b0;
      second_tier_alarm_lamp_o  <= 1'b0;
      low_tier_alarm_lamp_o     <= 1'b0;
      far_terminal_alarm_lamp_o <= 1'b0;
      timing_lock_lamp_o        <= 1'b0;
      supply_a_lamp_o           <= faceplate_pkg::COL_OFF;
      supply_b_lamp_o           <= faceplate_pkg::COL_OFF;
      supply_alarm_o            <= 1'b0;
    end else if (clk_en_i) begin
      severe_alarm_lamp_o       <= s_alarm.critical;
      second_tier_alarm_lamp_o  <= s_alarm.major;
      low_tier_alarm_lamp_o     <= s_alarm.minor;
      far_terminal_alarm_lamp_o <= s_alarm.remote;
      timing_lock_lamp_o        <= s_lock;
      supply_a_lamp_o           <= band_a;
      supply_b_lamp_o           <= band_b;
      supply_alarm_o            <= sup_bad_a | sup_bad_b;
    end
  end

  // alarm-silence machine; new alarm = a rising alarm bit
  // broken: a fresh alarm cancelled the silence, and a
  // further press may silence again; a press with no
  // alarm present is ignored
  faceplate_pkg::silence_t sil_q;
  logic [5:0]              alm_vec;
  logic [5:0]              alm_prev_q;
  logic                    btn_prev_q;
  logic                    btn_press;
  logic                    new_alarm;

  assign alm_vec   = {s_alarm, sup_bad_a, sup_bad_b};
  assign btn_press = s_button & ~btn_prev_q;
  assign new_alarm = |(alm_vec & ~alm_prev_q);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alm_prev_q <= '0;
      btn_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      alm_prev_q <= alm_vec;
      btn_prev_q <= s_button;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sil_q <= faceplate_pkg::SIL_IDLE;
    end else if (clk_en_i) begin
      case (sil_q)
        faceplate_pkg::SIL_IDLE: begin
          if (btn_press && any_alarm) begin
            sil_q <= faceplate_pkg::SIL_ACTIVE;
          end
        end
        faceplate_pkg::SIL_ACTIVE: begin
          if (!any_alarm) begin
            sil_q <= faceplate_pkg::SIL_IDLE;
          end else if (new_alarm) begin
            sil_q <= faceplate_pkg::SIL_BROKEN;
          end
        end
        faceplate_pkg::SIL_BROKEN: begin
          if (!any_alarm) begin
            sil_q <= faceplate_pkg::SIL_IDLE;
          end else if (btn_press) begin
            sil_q <= faceplate_pkg::SIL_ACTIVE;
          end
        end
        default: begin
          sil_q <= faceplate_pkg::SIL_IDLE;
        end
      endcase
    end
  end

  // silence lamp and audible relay closure
  // relay closes while any alarm is present and silencing does not hold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alarm_silence_lamp_o <= 1'b0;
      audible_relay_o      <= 1'b0;
    end else if (clk_en_i) begin
      alarm_silence_lamp_o <= (sil_q == faceplate_pkg::SIL_ACTIVE);
      audible_relay_o      <= any_alarm
                            & (sil_q != faceplate_pkg::SIL_ACTIVE);
    end
  end

  // sticky event flags; a set in the clear cycle wins
  // supply events are rising edges of the bad flags; irq_o
  // uses the next status so it rises with the flag, while
  // an enable change shows one cycle later
  logic [faceplate_pkg::EV_W-1:0] ev;
  logic [faceplate_pkg::EV_W-1:0] ev_clr;
  logic                           sup_a_prev_q;
  logic                           sup_b_prev_q;

  assign ev[faceplate_pkg::EV_SUPPLY_A] = sup_bad_a & ~sup_a_prev_q;
  assign ev[faceplate_pkg::EV_SUPPLY_B] = sup_bad_b & ~sup_b_prev_q;
  assign ev[faceplate_pkg::EV_SILENCE]  = btn_press;
  assign ev[faceplate_pkg::EV_NEWALARM] = new_alarm;
  assign ev_clr = (reg_wr_i && reg_addr_i == faceplate_pkg::OFS_IRQ_CL)
                ? reg_wdata_i[faceplate_pkg::EV_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_st_q     <= '0;
      sup_a_prev_q <= 1'b0;
      sup_b_prev_q <= 1'b0;
      irq_o        <= 1'b0;
    end else if (clk_en_i) begin
      sup_a_prev_q <= sup_bad_a;
      sup_b_prev_q <= sup_bad_b;
      irq_st_q     <= (irq_st_q & ~ev_clr) | ev;
      irq_o        <= |(((irq_st_q & ~ev_clr) | ev) & irq_en_q);
    end
  end

  // register writes
  // read-only and unmapped words ignore writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q   <= faceplate_pkg::CTRL_RESET;
      div_q    <= BLINK_HALF_CYC[faceplate_pkg::DIV_W-1:0];
      irq_en_q <= '0;
    end else if (clk_en_i && reg_wr_i) begin
      case (reg_addr_i)
        faceplate_pkg::OFS_CTRL: begin
          ctrl_q <= reg_wdata_i[7:0];
        end
        faceplate_pkg::OFS_DIV: begin
          if (reg_wdata_i[faceplate_pkg::DIV_W-1:0] != '0) begin
            div_q <= reg_wdata_i[faceplate_pkg::DIV_W-1:0];
          end
        end
        faceplate_pkg::OFS_IRQ_EN: begin
          irq_en_q <= reg_wdata_i[faceplate_pkg::EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // register reads, data in the following cycle
  // a cycle with no read strobe returns zero, so the
  // data bus may be or-ed with other slaves
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr_i)
      faceplate_pkg::OFS_CTRL:   rd_mux = {24'h000000, ctrl_q};
      faceplate_pkg::OFS_STATUS: rd_mux = {23'h000000, sil_q, sync2_q[18:13]};
      faceplate_pkg::OFS_IRQ_ST: rd_mux = {28'h0000000, irq_st_q};
      faceplate_pkg::OFS_IRQ_EN: rd_mux = {28'h0000000, irq_en_q};
      faceplate_pkg::OFS_DIV:    rd_mux = {4'h0, div_q};
      // lamp word, low bit first: supply alarm, fail,
      // silence, relay, role, supply A, supply B
      faceplate_pkg::OFS_LAMPS:  rd_mux = {22'h000000, supply_b_lamp_o,
                                           supply_a_lamp_o, role_lamp_o,
                                           audible_relay_o,
                                           alarm_silence_lamp_o,
                                           fail_lamp_o, supply_alarm_o};
      default:                   rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else if (clk_en_i) begin
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end

endmodule : faceplate_alarm_indicators

/* rtl/faceplate_pkg.sv */
// package for the faceplate lamp and alarm-silence block
// assumes one 250 MHz system clock; all users name package::item
package faceplate_pkg;

  // clock rate and blink half period
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
  localparam int unsigned DIV_W          = 28;

  // register offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_ST = 4'h2;
  localparam logic [3:0] OFS_IRQ_EN = 4'h3;
  localparam logic [3:0] OFS_IRQ_CL = 4'h4;
  localparam logic [3:0] OFS_DIV    = 4'h5;
  localparam logic [3:0] OFS_LAMPS  = 4'h6;

  // control field positions
  localparam int unsigned CTRL_BLINK_OFF = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // interrupt event bit positions
  localparam int unsigned EV_SUPPLY_A = 0;
  localparam int unsigned EV_SUPPLY_B = 1;
  localparam int unsigned EV_SILENCE  = 2;
  localparam int unsigned EV_NEWALARM = 3;
  localparam int unsigned EV_W        = 4;

  // lamp colour code
  typedef enum logic [1:0] {
    COL_OFF   = 2'h0,
    COL_GREEN = 2'h1,
    COL_AMBER = 2'h2,
    COL_RED   = 2'h3
  } colour_t;

  // threshold comparisons for one supply, raw at the pins or synchronised
  typedef struct packed {
    logic above_ext_high;
    logic above_high;
    logic below_low;
    logic below_ext_low;
  } supply_cmp_t;

  // local and remote alarm presence
  typedef struct packed {
    logic critical;
    logic major;
    logic minor;
    logic remote;
  } alarm_in_t;

  // alarm-silence states
  typedef enum logic [2:0] {
    SIL_IDLE   = 3'b001,
    SIL_ACTIVE = 3'b010,
    SIL_BROKEN = 3'b100
  } silence_t;

endpackage : faceplate_pkg

/* verif/faceplate_alarm_indicators_asserts.sv */
// port checks for the faceplate lamp block
// assumes clk_en_i held high; bound into every block instance
`timescale 1ns/100ps
module faceplate_alarm_indicators_asserts (
  input wire logic                       clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       card_reset_i,
  input wire logic                       db_write_i,
  input wire logic                       role_active_i,
  input wire faceplate_pkg::alarm_in_t   alarms_i,
  input wire logic                       timing_locked_i,
  input wire faceplate_pkg::supply_cmp_t supply_a_i,
  input wire faceplate_pkg::supply_cmp_t supply_b_i,
  input wire logic [3:0]                 reg_addr_i,
  input wire logic                       reg_rd_i,
  input wire logic [31:0]                reg_rdata_o,
  input wire logic                       fail_lamp_o,
  input wire faceplate_pkg::colour_t     role_lamp_o,
  input wire logic                       severe_alarm_lamp_o,
  input wire logic                       second_tier_alarm_lamp_o,
  input wire logic                       low_tier_alarm_lamp_o,
  input wire logic                       far_terminal_alarm_lamp_o,
  input wire logic                       timing_lock_lamp_o,
  input wire logic                       alarm_silence_lamp_o,
  input wire logic                       audible_relay_o,
  input wire faceplate_pkg::colour_t     supply_a_lamp_o,
  input wire faceplate_pkg::colour_t     supply_b_lamp_o,
  input wire logic                       supply_alarm_o
);
  logic [2:0] up_q;
  // edges since reset release, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  // colour band with red over amber over green
  function automatic logic [1:0] band(input logic [3:0] c);
    return (c[3] | c[0]) ? 2'h3 : ((c[2] | c[1]) ? 2'h2 : 2'h1);
  endfunction : band
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_fail; up_q == 3'h7 && $past(card_reset_i, 3) |-> fail_lamp_o;
  endproperty
  property p_role; up_q == 3'h7 && !$past(db_write_i, 3) &&
    !$past(card_reset_i, 3) |-> role_lamp_o == ($past(role_active_i, 3) ?
    faceplate_pkg::COL_GREEN : faceplate_pkg::COL_AMBER); endproperty
  property p_sev; up_q == 3'h7 |->
    severe_alarm_lamp_o == $past(alarms_i.critical, 3); endproperty
  property p_maj; up_q == 3'h7 |->
    second_tier_alarm_lamp_o == $past(alarms_i.major, 3); endproperty
  property p_min; up_q == 3'h7 |->
    low_tier_alarm_lamp_o == $past(alarms_i.minor, 3); endproperty
  property p_far; up_q == 3'h7 |->
    far_terminal_alarm_lamp_o == $past(alarms_i.remote, 3); endproperty
  property p_lock; up_q == 3'h7 |->
    timing_lock_lamp_o == $past(timing_locked_i, 3); endproperty
  property p_sup_a; up_q == 3'h7 |->
    supply_a_lamp_o == band($past(supply_a_i, 3)); endproperty
  property p_sup_b; up_q == 3'h7 |->
    supply_b_lamp_o == band($past(supply_b_i, 3)); endproperty
  property p_sil; alarm_silence_lamp_o |-> !audible_relay_o; endproperty
  property p_unmap; reg_rd_i && reg_addr_i > 4'h6 |=>
    reg_rdata_o == 32'h0; endproperty
  a_fail: assert property (p_fail) else $error("fail lamp dark");
  a_role: assert property (p_role) else $error("role colour");
  a_sev: assert property (p_sev) else $error("severe lamp");
  a_maj: assert property (p_maj) else $error("second tier lamp");
  a_min: assert property (p_min) else $error("low tier lamp");
  a_far: assert property (p_far) else $error("far lamp");
  a_lock: assert property (p_lock) else $error("lock lamp");
  a_sup_a: assert property (p_sup_a) else $error("supply a");
  a_sup_b: assert property (p_sup_b) else $error("supply b");
  a_sil: assert property (p_sil) else $error("relay while silenced");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // main scenarios reached
  c_sil: cover property ($rose(alarm_silence_lamp_o));
  c_red: cover property (supply_a_lamp_o == faceplate_pkg::COL_RED);
  c_flash: cover property ($fell(fail_lamp_o));
endmodule : faceplate_alarm_indicators_asserts
bind faceplate_alarm_indicators faceplate_alarm_indicators_asserts
  faceplate_alarm_indicators_asserts_inst (.*);

/* verif/faceplate_panel.sv */
// front panel model: a pushbutton held by a hand, and the horn
// assumes press_i is a one-cycle request from the bench
`timescale 1ns/100ps
module faceplate_panel (
  input  wire logic       clk_i,
  input  wire logic       press_i,
  input  wire logic [3:0] hold_i,
  input  wire logic       relay_i,
  output logic            button_o,
  output logic            sounding_o
);
  logic [3:0] left_q = 4'h0;
  // button stays down for hold_i cycles, short or slow hands
  always_ff @(posedge clk_i) begin
    if (press_i) left_q <= hold_i;
    else if (left_q != 4'h0) left_q <= left_q - 4'h1;
  end
  assign button_o   = (left_q != 4'h0);
  assign sounding_o = relay_i; // horn follows the closure
endmodule : faceplate_panel

/* verif/test_faceplate_alarm_indicators.sv */
// self-checking bench for the faceplate lamp block
// assumes short blink divider of 4 cycles, clk_en_i tied high
`timescale 1ns/100ps
module test_faceplate_alarm_indicators;
  localparam int unsigned HALF = 4;
  logic clk_i = 1'b0, rst_n_i = 1'b0, press = 1'b0, button, horn;
  logic card_reset_i, booting_i, writing_i, db_write_i, role_active_i;
  logic timing_locked_i, reg_wr_i, reg_rd_i, irq_o, fail_lamp_o;
  logic severe_alarm_lamp_o, second_tier_alarm_lamp_o, supply_alarm_o;
  logic low_tier_alarm_lamp_o, far_terminal_alarm_lamp_o;
  logic timing_lock_lamp_o, alarm_silence_lamp_o, audible_relay_o;
  logic [3:0] reg_addr_i, hold;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  faceplate_pkg::alarm_in_t alarms_i;
  faceplate_pkg::supply_cmp_t supply_a_i, supply_b_i;
  faceplate_pkg::colour_t role_lamp_o, supply_a_lamp_o, supply_b_lamp_o;
  int mismatches = 0, check_count = 0, fl, rl;
  logic [6:0] steps[$] = '{7'h41, 7'h46, 7'h61, 7'h00,
                           7'h46, 7'h00, 7'h11, 7'h04};
  faceplate_alarm_indicators #(.BLINK_HALF_CYC(HALF))
    faceplate_alarm_indicators_inst (.*, .clk_en_i(1'b1),
    .silence_button_i(button));
  faceplate_panel faceplate_panel_inst (.clk_i(clk_i), .press_i(press),
    .hold_i(hold), .relay_i(audible_relay_o), .button_o(button),
    .sounding_o(horn));
  always #2 clk_i = ~clk_i;
  // expected colour band, red over amber over green
  function automatic logic [1:0] band(input logic [3:0] c);
    return (c[3] | c[0]) ? 2'h3 : ((c[2] | c[1]) ? 2'h2 : 2'h1);
  endfunction : band
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1; // next strobe is raised off this edge
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  // counts lamp changes over 64 cycles
  task automatic flips(output int f, output int r);
    logic f0;
    faceplate_pkg::colour_t r0;
    f = 0;
    r = 0;
    f0 = fail_lamp_o;
    r0 = role_lamp_o;
    repeat (64) begin
      @(posedge clk_i);
      #1;
      f += (fail_lamp_o != f0);
      r += (role_lamp_o != r0);
      f0 = fail_lamp_o;
      r0 = role_lamp_o;
    end
  endtask : flips
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(28929));
    {card_reset_i, booting_i, writing_i, db_write_i} = 4'h0;
    {role_active_i, timing_locked_i, reg_wr_i, reg_rd_i} = 4'h0;
    {alarms_i, supply_a_i, supply_b_i, reg_addr_i, hold} = 20'h0;
    reg_wdata_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk(fail_lamp_o, 1);
    rd(faceplate_pkg::OFS_DIV, d);
    chk(d, HALF);
    wr(faceplate_pkg::OFS_DIV, 32'h0);
    rd(faceplate_pkg::OFS_DIV, d);
    chk(d, HALF);
    rd(4'h7, d);
    chk(d, 32'h0);
    card_reset_i <= 1'b1;
    settle();
    flips(fl, rl);
    chk({fl[7:0], fail_lamp_o}, 9'h1);
    card_reset_i <= 1'b0;
    settle();
    chk(fail_lamp_o, 0);
    for (int k = 0; k < 3; k++) begin
      booting_i <= (k == 0);
      writing_i <= (k != 0);
      if (k == 2) wr(faceplate_pkg::OFS_DIV, 32'h8);
      settle();
      flips(fl, rl);
      d = (k == 2) ? 64 / 8 : 64 / HALF;
      chk(fl >= d - 1 && fl <= d + 1, 1);
    end
    {booting_i, writing_i} <= 2'h0;
    wr(faceplate_pkg::OFS_DIV, HALF);
    for (int k = 0; k < 2; k++) begin
      role_active_i <= k[0];
      settle();
      chk(role_lamp_o, k ? 2'h1 : 2'h2);
    end
    db_write_i <= 1'b1;
    settle();
    flips(fl, rl);
    chk(rl >= 64 / HALF - 1, 1);
    wr(faceplate_pkg::OFS_CTRL, 32'h1);
    settle();
    flips(fl, rl);
    chk(rl, 0);
    db_write_i <= 1'b0;
    repeat (16) begin
      alarms_i <= faceplate_pkg::alarm_in_t'($urandom_range(15));
      timing_locked_i <= $urandom_range(1);
      settle();
      chk(severe_alarm_lamp_o, alarms_i.critical);
      chk(second_tier_alarm_lamp_o, alarms_i.major);
      chk(low_tier_alarm_lamp_o, alarms_i.minor);
      chk(far_terminal_alarm_lamp_o, alarms_i.remote);
      chk(timing_lock_lamp_o, timing_locked_i);
      chk(audible_relay_o, |alarms_i);
    end
    alarms_i <= 4'h0;
    wr(faceplate_pkg::OFS_IRQ_CL, 32'hf);
    wr(faceplate_pkg::OFS_IRQ_EN, 32'h1);
    for (int v = 0; v < 16; v++) begin
      supply_a_i <= v[3:0];
      supply_b_i <= $urandom_range(15);
      settle();
      chk(supply_a_lamp_o, band(supply_a_i));
      chk(supply_b_lamp_o, band(supply_b_i));
      chk(supply_alarm_o, (supply_a_i | supply_b_i) != 0);
    end
    chk(irq_o, 1);
    {supply_a_i, supply_b_i} <= 8'h0;
    settle();
    wr(faceplate_pkg::OFS_IRQ_CL, 32'hf);
    #1 chk(irq_o, 0);
    supply_a_i <= 4'h1;
    settle();
    chk(irq_o, 1);
    wr(faceplate_pkg::OFS_IRQ_EN, 32'h0);
    @(posedge clk_i);
    #1 chk(irq_o, 0);
    rd(faceplate_pkg::OFS_IRQ_ST, d);
    chk(d[0], 1);
    supply_a_i <= 4'h0;
    settle();
    wr(faceplate_pkg::OFS_IRQ_CL, 32'hf);
    foreach (steps[i]) begin
      alarms_i <= steps[i][6:3];
      settle();
      if (steps[i][2]) begin
        hold  <= $urandom_range(8, 2);
        press <= 1'b1;
        @(posedge clk_i);
        press <= 1'b0;
        repeat (3) settle();
      end
      chk(alarm_silence_lamp_o, steps[i][1]);
      chk(horn, steps[i][0]);
    end
    rd(faceplate_pkg::OFS_IRQ_ST, d);
    chk(d[3:2], 2'h3);
    rd(faceplate_pkg::OFS_STATUS, d);
    chk(d, 32'h42);
    rd(faceplate_pkg::OFS_LAMPS, d);
    chk(d, 32'h150);
    complete_run();
  end
endmodule : test_faceplate_alarm_indicators
